// ---- include/opv_params.svh ----
// opv constants: offsets, encodings, reset values and timing counts
`ifndef OPV_PARAMS_SVH
`define OPV_PARAMS_SVH
`define OPV_CLK_HZ          50000000
`define OPV_PSAVE_DLY_US    520
`define OPV_PSAVE_DLY_CYC   ((`OPV_PSAVE_DLY_US * 50) - 1)
`define OPV_STARTUP_US      170
`define OPV_STARTUP_CYC     (`OPV_STARTUP_US * 50)
`define OPV_ACK_VALID_US    2
`define OPV_ACK_VALID_CYC   (`OPV_ACK_VALID_US * 50)
`define OPV_ACK_LOW_US      512
`define OPV_ACK_LOW_CYC     (`OPV_ACK_LOW_US * 50)
`define OPV_EOS_US          2
`define OPV_EOS_CYC         (`OPV_EOS_US * 50)
`define OPV_DEV_ADDR        8'hA5
`define OPV_SEL_CONV_A      2'h1
`define OPV_SEL_CONV_B      2'h2
`define OPV_VOLT_RST        5'h00
`define OPV_HALF_PERIOD_CYC 11
`define OPV_DATA_ACKREQ_BIT 7
`define OPV_DATA_SEL_HI     6
`define OPV_DATA_SEL_LO     5
`endif

// ---- include/opv_pkg.sv ----
// opv package: state types of the one-pin voltage interface
package opv_pkg;
	typedef enum logic [2:0] {
		OPV_RX_OFF,
		OPV_RX_WAKE,
		OPV_RX_IDLE,
		OPV_RX_LOW,
		OPV_RX_HIGH,
		OPV_RX_ACK_WAIT,
		OPV_RX_ACK_DRIVE
	} opv_rx_state_t;
	typedef logic [4:0] opv_volt_t;
endpackage : opv_pkg

// ---- core/opv_fifo.sv ----
// opv_fifo: parameterised frame buffer with valid/ready on both sides
`timescale 1ns/1ps
module opv_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	// clock and reset
	input  wire logic             clk_sys,
	input  wire logic             nrst,
	// fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_r;
	logic [AW:0]      rd_r;
	wire              full_w  = (wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]);
	wire              empty_w = (wr_r == rd_r);
	wire              push_w  = in_valid && !full_w;
	wire              pop_w   = out_ready && !empty_w;
	assign in_ready  = !full_w;
	assign out_valid = !empty_w;
	assign out_data  = mem[rd_r[AW-1:0]];
	always_ff @(posedge clk_sys) begin
		if (push_w) mem[wr_r[AW-1:0]] <= in_data;
	end
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			wr_r <= '0;
			rd_r <= '0;
		end else begin
			if (push_w) wr_r <= wr_r + 1'b1;
			if (pop_w)  rd_r <= rd_r + 1'b1;
		end
	end
endmodule : opv_fifo

// ---- core/opv_core.sv ----
// opv_core: one-pin mode/data receiver, voltage registers and switch control
// How it works
// - line high forces pwm on both converters; low allows automatic pwm/pfm.
// - after line falls, power save enables only after the power-save delay.
// - forced pwm starts at once when the line samples high.
// - each converter has its own enable and its own run output.
// - both enables low means shutdown: switches, run outputs and core_active off; forced_pwm is not gated.
// - converter b high side turns on half a period after converter a.
// - high-side limit turns high side off, low side on until low limit clears.
// - over-temperature turns off both switches until the indication clears.
// - frame is address byte then data byte; act only on matching address.
// - data byte is ack request, two select bits, five value bits, msb first.
// - bytes arrive msb first and are shifted in that order.
// - bit decoding is ratio based, working from 1.7 to 160 kbit/s.
// - bit spans falling edge to falling edge; 2x ratio decides one or zero.
// - select 10 writes converter b, 01 converter a, 11 unused.
// - two five-bit voltage registers, 32 values each.
// - receiver active only with an enable high, and after 170 us start-up.
// - acknowledge only with request set, address match and all 16 bits good.
// - acknowledge waits the valid delay after last fall, then pulls low.
// - forced pwm holds throughout any frame reception.
// - a fall starts decoding; staying low for the delay enables power save.
// - voltage registers keep their values while both converters are disabled.
`timescale 1ns/1ps
`include "opv_params.svh"
module opv_core #(
	parameter int PSAVE_DLY_CYC = `OPV_PSAVE_DLY_CYC,
	parameter int STARTUP_CYC   = `OPV_STARTUP_CYC,
	parameter int ACK_LOW_CYC   = `OPV_ACK_LOW_CYC,
	parameter logic [7:0] DEV_ADDR = `OPV_DEV_ADDR,
	parameter int FIFO_DEPTH    = 32
) (
	// clock and reset
	input  wire logic             clk_sys,
	input  wire logic             nrst,
	// mode/data pin, open drain
	input  wire logic             mode_data_in,
	output logic                  mode_data_out,
	output logic                  ack_pulldown_switch,
	// converter enables and analog indications
	input  wire logic             conv_a_enable,
	input  wire logic             conv_b_enable,
	input  wire logic             conv_a_hs_limit,
	input  wire logic             conv_a_ls_limit,
	input  wire logic             conv_b_hs_limit,
	input  wire logic             conv_b_ls_limit,
	input  wire logic             over_temp,
	// power stage controls
	output logic                  forced_pwm,
	output logic                  conv_a_run,
	output logic                  conv_b_run,
	output logic                  conv_a_hs_on,
	output logic                  conv_a_ls_on,
	output logic                  conv_b_hs_on,
	output logic                  conv_b_ls_on,
	output logic                  core_active,
	// voltage settings
	output opv_pkg::opv_volt_t    conv_a_voltage_setting,
	output opv_pkg::opv_volt_t    conv_b_voltage_setting
);
	import opv_pkg::*;

	// ==========================================================
	// line sampling and timebase
	logic        line_r;
	logic [15:0] cnt_r;
	logic [15:0] low_t_r;
	logic [15:0] high_t_r;
	logic [15:0] wake_r;
	logic [4:0]  nbits_r;
	logic [15:0] shift_r;
	logic        psave_r;
	logic        ack_ok_r;
	opv_rx_state_t st_r;
	wire         any_en_w = conv_a_enable | conv_b_enable;
	wire         fall_w   = line_r & ~mode_data_in;
	wire         rise_w   = ~line_r & mode_data_in;
	// decide one bit from its low and high time, 2x ratio each way
	function automatic logic [1:0] bit_decode(input logic [15:0] tl, input logic [15:0] th);
		logic [16:0] tl2;
		logic [16:0] th2;
		tl2 = {tl, 1'b0};
		th2 = {th, 1'b0};
		if ({1'b0, th} >= tl2 && tl != 16'h0000) bit_decode = 2'h3;
		else if ({1'b0, tl} >= th2 && th != 16'h0000) bit_decode = 2'h2;
		else bit_decode = 2'h0;
	endfunction : bit_decode
	wire [1:0]   dec_w    = bit_decode(low_t_r, cnt_r);
	wire [15:0]  frame_w  = {shift_r[14:0], dec_w[0]};
	wire         addr_ok_w = (frame_w[15:8] == DEV_ADDR);
	wire         good_w   = dec_w[1] && (nbits_r == 5'h0F) && addr_ok_w;
	wire         cnt_sat_w = (cnt_r == 16'hFFFF);

	// ==========================================================
	// frame buffer between receiver and register write
	logic        fifo_in_ready;
	logic        fifo_out_valid;
	logic [7:0]  fifo_out_data;
	wire         push_w = (st_r == OPV_RX_HIGH) && fall_w && good_w && fifo_in_ready;
	opv_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk_sys   (clk_sys),
		.nrst      (nrst),
		.in_valid  (push_w),
		.in_ready  (fifo_in_ready),
		.in_data   (frame_w[7:0]),
		.out_valid (fifo_out_valid),
		.out_ready (1'b1),
		.out_data  (fifo_out_data)
	);

	// ==========================================================
	// receiver state machine
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			st_r    <= OPV_RX_OFF;
			line_r  <= 1'b0;
			cnt_r   <= 16'h0000;
			low_t_r <= 16'h0000;
			wake_r  <= 16'h0000;
			nbits_r <= 5'h00;
			shift_r <= 16'h0000;
			psave_r <= 1'b1;
			ack_ok_r <= 1'b0;
		end else begin
			line_r <= mode_data_in;
			if (!cnt_sat_w) cnt_r <= cnt_r + 16'h0001;
			if (mode_data_in) psave_r <= 1'b0;
			if (!any_en_w) begin
				st_r <= OPV_RX_OFF;
			end else case (st_r)
				OPV_RX_OFF: begin
					wake_r <= 16'h0000;
					st_r   <= OPV_RX_WAKE;
				end
				OPV_RX_WAKE: begin
					wake_r <= wake_r + 16'h0001;
					if (int'(wake_r) >= STARTUP_CYC - 1) st_r <= OPV_RX_IDLE;
				end
				OPV_RX_IDLE: begin
					if (fall_w) begin
						cnt_r   <= 16'h0000;
						nbits_r <= 5'h00;
						st_r    <= OPV_RX_LOW;
					end
				end
				OPV_RX_LOW: begin
					if (rise_w) begin
						low_t_r <= cnt_r;
						cnt_r   <= 16'h0000;
						st_r    <= OPV_RX_HIGH;
					end else if (int'(cnt_r) >= PSAVE_DLY_CYC) begin
						psave_r <= 1'b1;
						st_r    <= OPV_RX_IDLE;
					end
				end
				OPV_RX_HIGH: begin
					if (fall_w) begin
						cnt_r <= 16'h0000;
						if (dec_w[1]) begin
							shift_r <= frame_w;
							nbits_r <= nbits_r + 5'h01;
						end else begin
							nbits_r <= 5'h00;
						end
						if (nbits_r == 5'h0F) begin
							ack_ok_r <= good_w && frame_w[`OPV_DATA_ACKREQ_BIT];
							st_r     <= OPV_RX_ACK_WAIT;
						end else begin
							st_r <= OPV_RX_LOW;
						end
					end else if (cnt_sat_w) begin
						nbits_r <= 5'h00;
						st_r    <= OPV_RX_IDLE;
					end
				end
				OPV_RX_ACK_WAIT: begin
					if (int'(cnt_r) >= `OPV_ACK_VALID_CYC - 1) begin
						cnt_r <= 16'h0000;
						st_r  <= ack_ok_r ? OPV_RX_ACK_DRIVE : OPV_RX_IDLE;
					end
				end
				OPV_RX_ACK_DRIVE: begin
					if (int'(cnt_r) >= ACK_LOW_CYC - 1) st_r <= OPV_RX_IDLE;
				end
				default: st_r <= OPV_RX_OFF;
			endcase
		end
	end

	// ==========================================================
	// pin and mode outputs
	wire in_frame_w = (st_r == OPV_RX_LOW) || (st_r == OPV_RX_HIGH) || (st_r == OPV_RX_ACK_WAIT);
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			mode_data_out       <= 1'b0;
			ack_pulldown_switch <= 1'b0;
			forced_pwm          <= 1'b0;
		end else begin
			mode_data_out       <= 1'b0;
			ack_pulldown_switch <= (st_r == OPV_RX_ACK_DRIVE) && any_en_w;
			forced_pwm          <= mode_data_in || in_frame_w || !psave_r;
		end
	end

	// ==========================================================
	// voltage registers, retained while disabled
	wire [1:0] sel_w = {fifo_out_data[`OPV_DATA_SEL_HI], fifo_out_data[`OPV_DATA_SEL_LO]};
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			conv_a_voltage_setting <= `OPV_VOLT_RST;
			conv_b_voltage_setting <= `OPV_VOLT_RST;
		end else if (fifo_out_valid) begin
			if (sel_w == `OPV_SEL_CONV_A) conv_a_voltage_setting <= fifo_out_data[4:0];
			if (sel_w == `OPV_SEL_CONV_B) conv_b_voltage_setting <= fifo_out_data[4:0];
		end
	end

	// ==========================================================
	// switching phase and switch drive
	logic [4:0] ph_r;
	logic       lim_a_r;
	logic       lim_b_r;
	wire        per_end_w = (ph_r == 5'(2 * `OPV_HALF_PERIOD_CYC - 1));
	wire        hs_a_w = (ph_r < 5'(`OPV_HALF_PERIOD_CYC));
	wire        on_a_w = conv_a_enable && !over_temp;
	wire        on_b_w = conv_b_enable && !over_temp;
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			ph_r <= 5'h00;
			lim_a_r <= 1'b0;
			lim_b_r <= 1'b0;
			conv_a_run <= 1'b0;
			conv_b_run <= 1'b0;
			conv_a_hs_on <= 1'b0;
			conv_a_ls_on <= 1'b0;
			conv_b_hs_on <= 1'b0;
			conv_b_ls_on <= 1'b0;
			core_active <= 1'b0;
		end else begin
			ph_r <= per_end_w ? 5'h00 : ph_r + 5'h01;
			lim_a_r <= conv_a_hs_limit | (lim_a_r & conv_a_ls_limit);
			lim_b_r <= conv_b_hs_limit | (lim_b_r & conv_b_ls_limit);
			core_active  <= any_en_w;
			conv_a_run   <= on_a_w;
			conv_b_run   <= on_b_w;
			conv_a_hs_on <= on_a_w && hs_a_w && !conv_a_hs_limit && !lim_a_r;
			conv_a_ls_on <= on_a_w && (!hs_a_w || conv_a_hs_limit || lim_a_r);
			conv_b_hs_on <= on_b_w && !hs_a_w && !conv_b_hs_limit && !lim_b_r;
			conv_b_ls_on <= on_b_w && (hs_a_w || conv_b_hs_limit || lim_b_r);
		end
	end
endmodule : opv_core

// ---- tb/opv_core_assertions.sv ----
// opv_core_assertions: port-level checker bound to opv_core
`timescale 1ns/1ps
module opv_core_checker #(
	parameter int PSAVE_DLY_CYC = 200,
	parameter int ACK_LOW_CYC   = 40
) (
	// clock and reset
	input wire logic               clk_sys,
	input wire logic               nrst,
	// pin and inputs
	input wire logic               mode_data_in,
	input wire logic               ack_pulldown_switch,
	input wire logic               conv_a_enable,
	input wire logic               conv_b_enable,
	input wire logic               conv_a_hs_limit,
	input wire logic               over_temp,
	// outputs
	input wire logic               forced_pwm,
	input wire logic               core_active,
	input wire logic               conv_a_hs_on,
	input wire logic               conv_a_ls_on,
	input wire logic               conv_b_hs_on,
	input wire logic               conv_b_ls_on,
	input wire opv_pkg::opv_volt_t conv_a_voltage_setting
);
	import opv_pkg::*;
	// ==========
	// run lengths of low line and of acknowledge drive
	int low_cnt_r;
	int ack_cnt_r;
	always_ff @(posedge clk_sys) begin
		low_cnt_r <= (!nrst || mode_data_in) ? 0 : low_cnt_r + 1;
		ack_cnt_r <= (!nrst || !ack_pulldown_switch) ? 0 : ack_cnt_r + 1;
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	a_pwm_on_high: assert property ((conv_a_enable || conv_b_enable) && mode_data_in && $past(nrst)
		|=> forced_pwm || !(conv_a_enable || conv_b_enable)) else $error("forced pwm late");
	a_pwm_frame_hold: assert property ($fell(mode_data_in) && forced_pwm |=> forced_pwm [*8])
		else $error("forced pwm dropped at fall");
	a_psave_bound: assert property (low_cnt_r == PSAVE_DLY_CYC + 4 |-> !forced_pwm)
		else $error("power save not enabled");
	a_ack_length: assert property ($fell(ack_pulldown_switch) |-> ack_cnt_r == ACK_LOW_CYC)
		else $error("ack low time wrong");
	a_ack_after_low: assert property ($rose(ack_pulldown_switch) |-> !$past(mode_data_in, 90))
		else $error("ack without closing fall");
	a_volt_quiet: assert property ($changed(conv_a_voltage_setting) |-> !$past(mode_data_in))
		else $error("voltage changed outside frame end");
	a_limit_off: assert property ((conv_a_enable && !over_temp && conv_a_hs_limit) ##1
		(conv_a_enable && !over_temp && conv_a_hs_limit) |-> !conv_a_hs_on && conv_a_ls_on)
		else $error("high side on under limit");
	a_phase_apart: assert property (!(conv_a_hs_on && conv_b_hs_on) && !(conv_a_hs_on && conv_a_ls_on))
		else $error("switches on together");
	a_temp_off: assert property (over_temp ##1 over_temp
		|-> !(conv_a_hs_on || conv_a_ls_on || conv_b_hs_on || conv_b_ls_on)) else $error("switch on when hot");
	a_shutdown_off: assert property ((!conv_a_enable && !conv_b_enable) ##1 (!conv_a_enable && !conv_b_enable)
		|-> !core_active && !conv_a_hs_on && !conv_b_hs_on) else $error("active in shutdown");
endmodule : opv_core_checker

bind opv_core opv_core_checker #(.PSAVE_DLY_CYC(PSAVE_DLY_CYC), .ACK_LOW_CYC(ACK_LOW_CYC)) u_checker (
	.clk_sys(clk_sys), .nrst(nrst), .mode_data_in(mode_data_in), .ack_pulldown_switch(ack_pulldown_switch),
	.conv_a_enable(conv_a_enable), .conv_b_enable(conv_b_enable), .conv_a_hs_limit(conv_a_hs_limit),
	.over_temp(over_temp), .forced_pwm(forced_pwm), .core_active(core_active), .conv_a_hs_on(conv_a_hs_on),
	.conv_a_ls_on(conv_a_ls_on), .conv_b_hs_on(conv_b_hs_on), .conv_b_ls_on(conv_b_ls_on),
	.conv_a_voltage_setting(conv_a_voltage_setting));

// ---- tb/opv_host.sv ----
// opv_host: open-drain host model on the mode/data line
`timescale 1ns/1ps
module opv_host (
	// clock
	clk_sys,
	// line
	ack_pulldown_switch,
	line
);
	input  wire logic clk_sys;
	input  wire logic ack_pulldown_switch;
	output wire logic line;
	logic             drive_low = 1'b0;
	// open drain with pull-up, so a requested ack never fights the host
	assign line = !(drive_low || ack_pulldown_switch);
	task automatic bit_out(input logic b);
		drive_low = 1'b1; // each bit opens with a fall
		repeat (b ? 2 : 6) @(negedge clk_sys);
		drive_low = 1'b0;
		repeat (b ? 6 : 2) @(negedge clk_sys); // 3x ratio, clear of the 2x limit
	endtask : bit_out
	task automatic send_frame(input logic [15:0] frm, output logic acked);
		repeat (10) @(negedge clk_sys); // line high before the first fall
		for (int i = 15; i >= 0; i--) begin
			bit_out(frm[i]); // msb first
		end
		drive_low = 1'b1; // closing fall ends the stream, held through the valid delay
		repeat (105) @(negedge clk_sys);
		drive_low = 1'b0;
		@(negedge clk_sys);
		acked = !line; // low after release means acknowledged
		repeat (60) @(negedge clk_sys); // reuse only after the ack ends
	endtask : send_frame
endmodule : opv_host

// ---- tb/opv_core_bench.sv ----
// opv_core_bench: directed tests of the one-pin voltage interface
`timescale 1ns/1ps
module opv_core_bench;
	import opv_pkg::*;
	logic      clk_sys = 1'b0;
	logic      nrst = 1'b0;
	logic      en_a = 1'b0, en_b = 1'b0, hot = 1'b0, lim_a = 1'b0, lim_b = 1'b0;
	logic      line, ack_pd, fpwm, run_a, run_b, active, acked, md_out;
	opv_volt_t volt_a, volt_b, ea, eb;
	int        errors = 0;
	int        num_checks = 0;
	always #10 clk_sys = ~clk_sys;
	opv_host u_host (.clk_sys(clk_sys), .ack_pulldown_switch(ack_pd), .line(line));
	opv_core #(.PSAVE_DLY_CYC(200), .STARTUP_CYC(50), .ACK_LOW_CYC(40)) u_dut (
		.clk_sys(clk_sys), .nrst(nrst), .mode_data_in(line), .mode_data_out(md_out), .ack_pulldown_switch(ack_pd),
		.conv_a_enable(en_a), .conv_b_enable(en_b), .conv_a_hs_limit(lim_a), .conv_a_ls_limit(lim_a),
		.conv_b_hs_limit(lim_b), .conv_b_ls_limit(lim_b), .over_temp(hot), .forced_pwm(fpwm), .conv_a_run(run_a),
		.conv_b_run(run_b), .conv_a_hs_on(), .conv_a_ls_on(), .conv_b_hs_on(), .conv_b_ls_on(), .core_active(active),
		.conv_a_voltage_setting(volt_a), .conv_b_voltage_setting(volt_b));
	task automatic check(input opv_volt_t got, input opv_volt_t exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : check
	task automatic done(input string name);
		$display("test %0s finished", name);
	endtask : done
	task automatic complete_run;
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : complete_run
	task automatic send(input logic [7:0] addr, input logic [7:0] data, input logic exp_ack);
		u_host.send_frame({addr, data}, acked);
		check(5'(acked), 5'(exp_ack));
		check(volt_a, ea);
		check(volt_b, eb);
	endtask : send
	initial begin
		repeat (16) @(negedge clk_sys);
		nrst = 1'b1;
		ea = 5'h00;
		eb = 5'h00;
		repeat (2) @(negedge clk_sys);
		check(volt_a, ea);
		check(5'(active), 5'h0);
		check(5'(md_out), 5'h0);
		en_a = 1'b1;
		repeat (60) @(negedge clk_sys);
		check(5'({run_b, run_a, active}), 5'h3);
		done("enable");
		// every select code, reserved ones write nothing
		for (int s = 0; s < 4; s++) begin
			if (s == 1) ea = 5'h11;
			if (s == 2) eb = 5'h12;
			send(8'hA5, {1'b1, 2'(s), 5'(5'h10 + s)}, 1'b1);
		end
		ea = 5'h0A;
		send(8'hA5, 8'h2A, 1'b0);
		eb = 5'h1F;
		send(8'hA5, 8'hDF, 1'b1);
		send(8'h25, 8'hA1, 1'b0);
		send(8'hA4, 8'hC1, 1'b0);
		done("frames");
		u_host.drive_low = 1'b1;
		repeat (260) @(negedge clk_sys);
		check(5'(fpwm), 5'h0);
		u_host.drive_low = 1'b0;
		repeat (2) @(negedge clk_sys);
		check(5'(fpwm), 5'h1);
		done("mode");
		en_b = 1'b1;
		lim_a = 1'b1;
		lim_b = 1'b1;
		repeat (30) @(negedge clk_sys);
		lim_a = 1'b0;
		lim_b = 1'b0;
		hot = 1'b1;
		repeat (4) @(negedge clk_sys);
		check(5'({run_b, run_a}), 5'h0);
		hot = 1'b0;
		repeat (4) @(negedge clk_sys);
		check(5'({run_b, run_a}), 5'h3);
		done("protect");
		en_a = 1'b0;
		en_b = 1'b0;
		repeat (4) @(negedge clk_sys);
		check(5'(active), 5'h0);
		send(8'hA5, 8'hA3, 1'b0);
		en_a = 1'b1;
		send(8'hA5, 8'hA3, 1'b0);
		ea = 5'h03;
		send(8'hA5, 8'hA3, 1'b1);
		done("retain");
		// successive frames each pass through the frame buffer to converter a
		for (int i = 0; i < 4; i++) begin
			ea = 5'(7 * i + 1);
			send(8'hA5, {3'h1, 5'(7 * i + 1)}, 1'b0);
		end
		done("fifo");
		complete_run();
	end
	initial begin
		repeat (20000) @(posedge clk_sys);
		errors++;
		complete_run();
	end
endmodule : opv_core_bench
